// ---- mcas_top.sv ----
`timescale 1ns/1ps
// Functional notes
// - current result is signed shunt reading times scale value, shifted right by CUR_SHIFT and saturated.
// - scale value sets the weight of current and power counts.
// - scale_factor at 05h, bit 15 unused, bits 14..0 scale, resets zero.
// - current_result at 04h is read only; writes leave it unchanged.
// - alert_source_select at 06h: enables 15..10, reserved 9..5, flags 4..2, polarity 1, latch select 0.
// - alert_source_select picks the function driving the alert pin and its behaviour.
// - with several limit enables set, only the highest one is compared.
// - bits 15/13 alert on shunt/rail above limit, 14/12 below limit.
// - bit 11 alerts when power result exceeds the limit.
// - bit 10 also drives the alert when the conversion-done flag sets.
// - latch mode clears hit flag on read; transparent clears after clean conversion.
// - polarity 0 gives active-low alert, 1 gives active-high.
module mcas_top #(
  parameter int CUR_SHIFT = mcas_pkg::CUR_SHIFT_DEF,
  parameter int PWR_SHIFT = mcas_pkg::PWR_SHIFT_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic signed [15:0] shuntVolt,
  input wire logic [15:0] railVolt,
  input wire logic [15:0] alertLimit,
  input wire logic convDone,
  output logic [15:0] powerResult,
  output logic alertOut,
  output logic alertOe
);
  logic [14:0] scale_r, scale_nxt;
  logic signed [15:0] current_r, current_nxt;
  logic [15:0] power_r, power_nxt;
  logic [5:0] enable_r, enable_nxt;
  logic pinPol_r, pinPol_nxt;
  logic latchSel_r, latchSel_nxt;
  logic hitFlag_r, hitFlag_nxt;
  logic doneFlag_r, doneFlag_nxt;
  logic ovfFlag_r, ovfFlag_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic alertOe_r, alertOe_nxt;
  logic signed [15:0] mathCurrent;
  logic [15:0] mathPower;
  logic mathOvf;
  logic funcHit;
  logic alertActive;
  logic selRead;

  mcas_math #(
    .CUR_SHIFT(CUR_SHIFT),
    .PWR_SHIFT(PWR_SHIFT)
  ) uMath (
    .shuntVolt(shuntVolt),
    .railVolt(railVolt),
    .scaleBits(scale_r),
    .currentVal(mathCurrent),
    .powerVal(mathPower),
    .mathOvf(mathOvf)
  );

  // full alert_source_select word as software reads it
  function automatic logic [15:0] selWord(input logic [5:0] en, input logic hit,
                                          input logic done, input logic ovf,
                                          input logic power_over_enable, input logic lat);
    logic [15:0] w;
    w = mcas_pkg::ALERT_SEL_RST;
    w[mcas_pkg::SHUNT_OVER_BIT:mcas_pkg::DONE_TO_PIN_BIT] = en;
    w[mcas_pkg::FUNC_HIT_BIT] = hit;
    w[mcas_pkg::CONV_DONE_BIT] = done;
    w[mcas_pkg::MATH_OVF_BIT] = ovf;
    w[mcas_pkg::PIN_POL_BIT] = power_over_enable;
    w[mcas_pkg::LATCH_SEL_BIT] = lat;
    return w;
  endfunction

  // priority chain: highest set enable alone is compared
  always_comb begin
    if (enable_r[5]) begin
      funcHit = shuntVolt > $signed(alertLimit);
    end else if (enable_r[4]) begin
      funcHit = shuntVolt < $signed(alertLimit);
    end else if (enable_r[3]) begin
      funcHit = railVolt > alertLimit;
    end else if (enable_r[2]) begin
      funcHit = railVolt < alertLimit;
    end else if (enable_r[1]) begin
      funcHit = mathPower > alertLimit;
    end else begin
      funcHit = 1'b0;
    end
  end

  assign selRead = regRd && (regAddr == mcas_pkg::OFS_ALERT_SEL);

  // next register state; hardware sets win over read clears
  always_comb begin
    scale_nxt = scale_r;
    current_nxt = current_r;
    power_nxt = power_r;
    enable_nxt = enable_r;
    pinPol_nxt = pinPol_r;
    latchSel_nxt = latchSel_r;
    hitFlag_nxt = hitFlag_r;
    doneFlag_nxt = doneFlag_r;
    ovfFlag_nxt = ovfFlag_r;
    rdData_nxt = rdData_r;
    if (regWr && regAddr == mcas_pkg::OFS_SCALE) begin
      scale_nxt = regWrData[mcas_pkg::SCALE_W-1:0];
    end
    if (regWr && regAddr == mcas_pkg::OFS_ALERT_SEL) begin
      enable_nxt = regWrData[mcas_pkg::SHUNT_OVER_BIT:mcas_pkg::DONE_TO_PIN_BIT];
      pinPol_nxt = regWrData[mcas_pkg::PIN_POL_BIT];
      latchSel_nxt = regWrData[mcas_pkg::LATCH_SEL_BIT];
    end
    // read of the select word clears the sticky flags
    if (selRead) begin
      doneFlag_nxt = 1'b0;
      if (latchSel_r) begin
        hitFlag_nxt = 1'b0;
      end
    end
    // results and the overflow flag move only on a finished conversion
    if (convDone) begin
      current_nxt = mathCurrent;
      power_nxt = mathPower;
      ovfFlag_nxt = mathOvf;
      doneFlag_nxt = 1'b1;
      if (latchSel_r) begin
        // build on the read-cleared value so a read in this cycle is not lost
        hitFlag_nxt = hitFlag_nxt || funcHit;
      end else begin
        hitFlag_nxt = funcHit;
      end
    end
    // writes to 04h are simply not decoded
    if (regRd) begin
      unique case (regAddr)
        mcas_pkg::OFS_CURRENT: rdData_nxt = current_r;
        mcas_pkg::OFS_SCALE: rdData_nxt = {1'b0, scale_r};
        mcas_pkg::OFS_ALERT_SEL: rdData_nxt = selWord(enable_r, hitFlag_r, doneFlag_r,
                                                      ovfFlag_r, pinPol_r, latchSel_r);
        default: rdData_nxt = 16'h0000;
      endcase
    end
  end

  // pin: function flag, plus done flag when routed
  always_comb begin
    alertActive = hitFlag_nxt || (enable_nxt[0] && doneFlag_nxt);
    // open drain: pull low when the output level is low
    alertOe_nxt = pinPol_nxt ? !alertActive : alertActive;
  end

  // register all state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scale_r <= mcas_pkg::SCALE_RST;
      current_r <= 16'sh0000;
      power_r <= 16'h0000;
      enable_r <= mcas_pkg::ENABLE_RST;
      pinPol_r <= 1'b0;
      latchSel_r <= 1'b0;
      hitFlag_r <= 1'b0;
      doneFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      rdData_r <= 16'h0000;
      alertOe_r <= 1'b0;
    end else begin
      scale_r <= scale_nxt;
      current_r <= current_nxt;
      power_r <= power_nxt;
      enable_r <= enable_nxt;
      pinPol_r <= pinPol_nxt;
      latchSel_r <= latchSel_nxt;
      hitFlag_r <= hitFlag_nxt;
      doneFlag_r <= doneFlag_nxt;
      ovfFlag_r <= ovfFlag_nxt;
      rdData_r <= rdData_nxt;
      alertOe_r <= alertOe_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign powerResult = power_r;
  assign alertOut = 1'b0;
  assign alertOe = alertOe_r;

  a_scale_write: assert property (@(posedge clk) disable iff (!rst_b)
    regWr && regAddr == mcas_pkg::OFS_SCALE |=> scale_r == $past(regWrData[14:0]))
    else $error("scale write not stored");
  a_current_ro: assert property (@(posedge clk) disable iff (!rst_b)
    regWr && regAddr == mcas_pkg::OFS_CURRENT && !convDone |=> $stable(current_r))
    else $error("current result changed by a write");
  a_current_load: assert property (@(posedge clk) disable iff (!rst_b)
    convDone |=> current_r == $past(mathCurrent))
    else $error("current result not loaded on conversion");
  a_result_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !convDone |=> $stable(current_r) && $stable(power_r) && $stable(ovfFlag_r))
    else $error("result changed without conversion");
  a_prio_top: assert property (@(posedge clk) disable iff (!rst_b)
    enable_r[5] |-> funcHit == (shuntVolt > $signed(alertLimit)))
    else $error("highest enable not given priority");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
    latchSel_r && hitFlag_r && !selRead && !(regWr && regAddr == mcas_pkg::OFS_ALERT_SEL)
    |=> hitFlag_r [*1] ##1 1'b1)
    else $error("latched hit flag lost without read");
  a_trans_clear: assert property (@(posedge clk) disable iff (!rst_b)
    !latchSel_r && convDone && !funcHit |=> !hitFlag_r)
    else $error("transparent hit flag not cleared");
  a_done_wins: assert property (@(posedge clk) disable iff (!rst_b)
    convDone |=> doneFlag_r && (!(enable_r[0] && !pinPol_r) || alertOe_r))
    else $error("done flag missing or alert not driven");
  a_pin_pol: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 alertOe_r == (pinPol_r ^ (hitFlag_r || (enable_r[0] && doneFlag_r))))
    else $error("alert pin polarity wrong");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    regRd && regAddr == mcas_pkg::OFS_SCALE |=> regRdData == {1'b0, $past(scale_r)})
    else $error("scale readback wrong");
  a_read_clear: assert property (@(posedge clk) disable iff (!rst_b)
    latchSel_r && selRead && !(convDone && funcHit) |=> !hitFlag_r)
    else $error("latched hit flag not cleared by read");
endmodule

// ---- mcas_pkg.sv ----
package mcas_pkg;
  // register word width and offsets
  localparam int REG_W = 16;
  localparam logic [7:0] OFS_CURRENT = 8'h04;
  localparam logic [7:0] OFS_SCALE = 8'h05;
  localparam logic [7:0] OFS_ALERT_SEL = 8'h06;
  // scale_factor layout
  localparam int SCALE_W = 15;
  localparam logic [14:0] SCALE_RST = 15'h0000;
  // alert_source_select field positions
  localparam int SHUNT_OVER_BIT = 15;
  localparam int SHUNT_UNDER_BIT = 14;
  localparam int RAIL_OVER_BIT = 13;
  localparam int RAIL_UNDER_BIT = 12;
  localparam int POWER_OVER_BIT = 11;
  localparam int DONE_TO_PIN_BIT = 10;
  localparam int FUNC_HIT_BIT = 4;
  localparam int CONV_DONE_BIT = 3;
  localparam int MATH_OVF_BIT = 2;
  localparam int PIN_POL_BIT = 1;
  localparam int LATCH_SEL_BIT = 0;
  localparam int ENABLE_W = 6;
  localparam logic [5:0] ENABLE_RST = 6'h00;
  localparam logic [15:0] ALERT_SEL_RST = 16'h0000;
  // default result scaling shifts
  localparam int CUR_SHIFT_DEF = 11;
  localparam int PWR_SHIFT_DEF = 13;
endpackage

// ---- mcas_math.sv ----
`timescale 1ns/1ps
// multiplier path: current from shunt and scale, power from current and rail
module mcas_math #(
  parameter int CUR_SHIFT = mcas_pkg::CUR_SHIFT_DEF,
  parameter int PWR_SHIFT = mcas_pkg::PWR_SHIFT_DEF
) (
  input wire logic signed [15:0] shuntVolt,
  input wire logic [15:0] railVolt,
  input wire logic [14:0] scaleBits,
  output logic signed [15:0] currentVal,
  output logic [15:0] powerVal,
  output logic mathOvf
);
  logic signed [31:0] curProd;
  logic signed [31:0] curScaled;
  logic [15:0] curMag;
  logic [31:0] pwrProd;
  logic [31:0] pwrScaled;
  logic curOvf;

  // elaboration check: a shift past the word width leaves no usable result
  if (CUR_SHIFT < 0 || CUR_SHIFT > 15 || PWR_SHIFT < 0 || PWR_SHIFT > 15) begin
    $error("mcas_math: shift out of range");
  end

  // integer product; the scale value sets the weight of one count
  always_comb begin
    curProd = 32'(shuntVolt) * $signed({17'h00000, scaleBits});
    curScaled = curProd >>> CUR_SHIFT;
    curOvf = (curScaled > 32'sd32767) || (curScaled < -32'sd32768);
    // saturate rather than wrap so an overflow never flips the sign
    if (curScaled > 32'sd32767) begin
      currentVal = 16'sh7fff;
    end else if (curScaled < -32'sd32768) begin
      currentVal = -16'sh8000;
    end else begin
      currentVal = curScaled[15:0];
    end
    // power weight follows the current weight, so it rescales too
    curMag = currentVal[15] ? 16'(-currentVal) : currentVal;
    pwrProd = {16'h0000, curMag} * {16'h0000, railVolt};
    pwrScaled = pwrProd >> PWR_SHIFT;
    powerVal = (pwrScaled > 32'h0000ffff) ? 16'hffff : pwrScaled[15:0];
    mathOvf = curOvf || (pwrScaled > 32'h0000ffff);
  end
endmodule

// ---- mcas_host_model.sv ----
`timescale 1ns/1ps
// host side of the register port, one strobe cycle per access
module mcas_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdData
);
  // idle bus values at time zero
  initial begin
    regAddr = 8'hff;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // address and data are scrambled after release so stale values never help
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // read data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, regWr, regRd, convDone, alertOut, alertOe;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, railVolt, alertLimit, powerResult, rv;
  logic signed [15:0] shuntVolt;
  int fail_count = 0;
  int checked = 0;
  mcas_top i_mcas_top (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .shuntVolt(shuntVolt),
    .railVolt(railVolt), .alertLimit(alertLimit), .convDone(convDone),
    .powerResult(powerResult), .alertOut(alertOut), .alertOe(alertOe));
  mcas_host_model i_mcas_host_model (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  // system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_mcas_host_model.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    i_mcas_host_model.rd(a, rv);
    chk("register", rv, e);
  endtask
  task automatic pin(input logic e);
    chk("alertOe", {15'h0000, alertOe}, {15'h0000, e});
    chk("alertOut", {15'h0000, alertOut}, 16'h0000);
  endtask
  // one conversion pulse, results land at the taking edge
  task automatic conv(input logic [15:0] s, input logic [15:0] r, input logic [15:0] l);
    @(posedge clk);
    shuntVolt <= s;
    railVolt <= r;
    alertLimit <= l;
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rdchk(8'h05, 16'h0000);
    rdchk(8'h06, 16'h0000);
    pin(1'b0);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(8'h05, 16'hffff);
    rdchk(8'h05, 16'h7fff);
    wr(8'h06, 16'hffff);
    rdchk(8'h06, 16'hfc03);
    wr(8'h06, 16'h0000);
    wr(8'h07, 16'h5555);
    rdchk(8'h07, 16'h0000);
    $display("test registers done");
  endtask
  task automatic t_current;
    wr(8'h05, 16'h0800);
    conv(16'h0064, 16'h2000, 16'h7fff);
    rdchk(8'h04, 16'h0064);
    chk("powerResult", powerResult, 16'h0064);
    wr(8'h05, 16'h0400);
    conv(16'hff9c, 16'h2000, 16'h7fff);
    rdchk(8'h04, 16'hffce);
    chk("powerResult", powerResult, 16'h0032);
    wr(8'h04, 16'h1234);
    rdchk(8'h04, 16'hffce);
    wr(8'h05, 16'h7fff);
    conv(16'h7fff, 16'h2000, 16'h7fff);
    rdchk(8'h04, 16'h7fff);
    rdchk(8'h06, 16'h000c);
    $display("test current done");
  endtask
  // each limit enable against a high and a low sample; scale makes current equal shunt
  task automatic t_select;
    logic [15:0] en[5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
    logic [1:0] ex[5] = '{2'b10, 2'b01, 2'b10, 2'b01, 2'b10};
    wr(8'h05, 16'h0800);
    for (int i = 0; i < 5; i++) begin
      wr(8'h06, en[i]);
      conv(16'h0200, 16'h8000, 16'h0100);
      pin(ex[i][1]);
      rdchk(8'h06, en[i] | {11'h000, ex[i][1], 4'h8});
      conv(16'h0080, 16'h0080, 16'h0100);
      pin(ex[i][0]);
      rdchk(8'h06, en[i] | {11'h000, ex[i][0], 4'h8});
    end
    wr(8'h06, 16'h9000);
    conv(16'h0080, 16'h0080, 16'h0100);
    pin(1'b0);
    wr(8'h06, 16'h4800);
    conv(16'h0200, 16'h8000, 16'h0100);
    pin(1'b0);
    wr(8'h06, 16'h8000);
    conv(16'h0200, 16'h8000, 16'h0100);
    @(posedge clk);
    shuntVolt <= 16'h0000;
    repeat (3) @(posedge clk);
    #1;
    pin(1'b1);
    $display("test select done");
  endtask
  // latch, polarity and done-to-pin behaviour
  task automatic t_modes;
    wr(8'h06, 16'h8001);
    conv(16'h0200, 16'h8000, 16'h0100);
    conv(16'h0080, 16'h0080, 16'h0100);
    pin(1'b1);
    rdchk(8'h06, 16'h8019);
    repeat (2) @(posedge clk);
    #1;
    pin(1'b0);
    wr(8'h06, 16'h8002);
    conv(16'h0080, 16'h0080, 16'h0100);
    pin(1'b1);
    conv(16'h0200, 16'h8000, 16'h0100);
    pin(1'b0);
    wr(8'h06, 16'h0400);
    conv(16'h0080, 16'h0080, 16'h0100);
    pin(1'b1);
    rdchk(8'h06, 16'h0408);
    repeat (2) @(posedge clk);
    #1;
    pin(1'b0);
    // latch mode: a read and a clean conversion in the same cycle
    wr(8'h06, 16'h8001);
    conv(16'h0200, 16'h8000, 16'h0100);
    fork
      rdchk(8'h06, 16'h8019);
      conv(16'h0080, 16'h0080, 16'h0100);
    join
    pin(1'b0);
    rdchk(8'h06, 16'h8009);
    $display("test modes done");
  endtask
  // reset, then the scenarios in order
  initial begin
    rst_b = 1'b0;
    shuntVolt = 16'h0000;
    railVolt = 16'h0000;
    alertLimit = 16'h0000;
    convDone = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_regs;
    t_current;
    t_select;
    t_modes;
    conclude;
  end
  // hang guard, well beyond the roughly 150 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude;
  end
endmodule
